// file: rtl/scg_pkg.sv
// Constants, types and state encodings shared by both ends of the sleep clock gating link.
// How it works
// (RULE_01) Mode 111 with crystal enters Extended Standby.
// (RULE_02) Extended Standby equals Power-save plus main oscillator; code keeps asy in Power-save always, in Extended Standby only when async.
// (RULE_03) Extended Standby wakes after six oscillator cycles.
// (RULE_04) Each sleep mode keeps its own clock domains.
// (RULE_05) Each sleep mode accepts its own wake sources.
// (RULE_06) Timer oscillator stays on only for asynchronous timer2.
// (RULE_07) Outside Idle, lines 7..4 wake only level-triggered.
// (RULE_08) Four USB asynchronous sources can wake the core.
// (RULE_09) Gate bit stops peripheral clock and register access.
// (RULE_10) Clearing gate bit restarts clock, state intact.
// (RULE_11) Software disables a peripheral before gating it.
// (RULE_12) Gating acts in Active and Idle only.
// (RULE_13) First gate register layout; bits 4,1 read zero.
// (RULE_14) Timer2 gate acts only in synchronous mode.
// (RULE_15) Gated timer resumes counting from frozen state.
// (RULE_16) Software reinitialises serial and USB after ungating.
// (RULE_17) Converter off before gating; comparator loses multiplexer.
// (RULE_18) Second gate register layout; reserved bits read zero.
// (RULE_19) Converter enable survives every sleep mode.
// (RULE_20) Converter re-enable makes next conversion extended.
// (RULE_21) Standby modes only with an external crystal.
// (RULE_22) Sleep needs enable bit set, then sleep command.
// (RULE_23) Interrupt wake holds core four extra cycles.
// (RULE_24) Reserved or crystal-less standby request is ignored.
`default_nettype none
package scg_pkg;
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_NRM = 3'h1;
    localparam logic [2:0] MODE_PDOWN = 3'h2;
    localparam logic [2:0] MODE_PSAVE = 3'h3;
    localparam logic [2:0] MODE_STBY = 3'h6;
    localparam logic [2:0] MODE_XSTBY = 3'h7;
    // Clock domain positions in the domain enable vector.
    localparam int D_CPU = 0;
    localparam int D_FLASH = 1;
    localparam int D_IO = 2;
    localparam int D_ADC = 3;
    localparam int D_ASY = 4;
    localparam int D_MAIN = 5;
    localparam int D_TOSC = 6;
    // Peripheral positions in the peripheral clock enable vector.
    localparam int P_TWI = 0;
    localparam int P_TIM2 = 1;
    localparam int P_TIM0 = 2;
    localparam int P_TIM1 = 3;
    localparam int P_SPI = 4;
    localparam int P_ADC = 5;
    localparam int P_USB = 6;
    localparam int P_TIM3 = 7;
    localparam int P_USART1 = 8;
    // Gate register bit positions, writable masks and reset values.
    localparam int G0_TWI = 7;
    localparam int G0_TIM2 = 6;
    localparam int G0_TIM0 = 5;
    localparam int G0_TIM1 = 3;
    localparam int G0_SPI = 2;
    localparam int G0_ADC = 0;
    localparam logic [7:0] G0_MASK = 8'hED;
    localparam int G1_USB = 7;
    localparam int G1_TIM3 = 3;
    localparam int G1_USART1 = 0;
    localparam logic [7:0] G1_MASK = 8'h89;
    localparam logic [7:0] GATE_RST = 8'h00;
    // Wake timing in cycles of the running clock.
    localparam logic [7:0] XSTBY_WAKE_CYC = 8'h06;
    localparam logic [7:0] WAKE_HOLD_CYC = 8'h04;
    localparam logic [7:0] RUNNING_WAKE_CYC = 8'h01;
    // Register map of the controller end, byte addresses.
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_SLEEP = 5'h04;
    localparam logic [4:0] ADDR_GATE0 = 5'h08;
    localparam logic [4:0] ADDR_GATE1 = 5'h0C;
    localparam logic [4:0] ADDR_STATUS = 5'h10;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SE = 3;
    localparam int CTRL_T2AS = 4;
    localparam int CTRL_XTAL = 5;
    localparam int CTRL_CONV = 6;
    localparam logic [6:0] CTRL_RST = 7'h00;
    localparam int STAT_HALTED = 0;
    localparam int STAT_CONVX = 1;
    localparam int STAT_WOKE = 2;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SLEEP = 2'b01,
        ST_START = 2'b11,
        ST_HOLD = 2'b10
    } scg_state_type;
endpackage : scg_pkg
`default_nettype wire

// file: rtl/scg_link_if.sv
// Link between the controller end and the sleep clock gating device end.
`default_nettype none
interface scg_link_if;
    logic [2:0] sleep_mode_select;
    logic sleep_enable_bit;
    logic sleep_exec;
    logic [1:0] gate_wr;
    logic [7:0] gate_wdata;
    logic timer2_async_select;
    logic ext_crystal_sel;
    logic converter_on;
    logic core_halted;
    logic wake_go;
    logic [7:0] gate0_q;
    logic [7:0] gate1_q;
    logic conv_extended;
    modport dev (
        input sleep_mode_select, sleep_enable_bit, sleep_exec, gate_wr, gate_wdata,
        input timer2_async_select, ext_crystal_sel, converter_on,
        output core_halted, wake_go, gate0_q, gate1_q, conv_extended
    );
    modport cpu (
        output sleep_mode_select, sleep_enable_bit, sleep_exec, gate_wr, gate_wdata,
        output timer2_async_select, ext_crystal_sel, converter_on,
        input core_halted, wake_go, gate0_q, gate1_q, conv_extended
    );
endinterface : scg_link_if
`default_nettype wire

// file: rtl/scg_delay.sv
// Down counter that marks the last cycle of a loaded wait.
`default_nettype none
module scg_delay (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic START,
    input wire logic [7:0] LOAD,
    output logic DONE
);
    logic [7:0] cnt_reg;

    // A new start wins over the running count so waits can be chained.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cnt_reg <= 8'h00;
        end else if (START) begin
            cnt_reg <= LOAD;
        end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
        end
    end

    // Done marks the last cycle, so a load of N spans exactly N cycles.
    assign DONE = (cnt_reg == 8'h01);
endmodule : scg_delay
`default_nettype wire

// file: rtl/scg_dev.sv
// Device end: sleep state machine, clock domain enables and peripheral clock gates.
`default_nettype none
module scg_dev
    import scg_pkg::*;
#(
    parameter logic [7:0] PDOWN_STARTUP_CYC = 8'h10
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    scg_link_if.dev LINK,
    input wire logic [7:0] EXT_IRQ_REQ,
    input wire logic [3:0] EXT_HI_LEVEL,
    input wire logic PIN_CHANGE,
    input wire logic TWI_ADDR_MATCH,
    input wire logic TIMER2_EVENT,
    input wire logic SPM_READY,
    input wire logic CONV_DONE,
    input wire logic WDT_IRQ,
    input wire logic OTHER_IO_IRQ,
    input wire logic USB_SYNC_IRQ,
    input wire logic BUS_VOLTAGE_TRANSITION_IRQ,
    input wire logic BUS_WAKE_IRQ,
    input wire logic ID_PIN_TRANSITION_IRQ,
    input wire logic HOST_WAKE_IRQ,
    input wire logic CONV_START,
    output logic [6:0] DOMAIN_EN,
    output logic [8:0] PERIPH_CLK_EN,
    output logic CONV_ENABLED,
    output logic CONV_EXTENDED,
    output logic CMP_MUX_ALLOW
);
    scg_state_type state_reg, state_next;
    logic [2:0] mode_reg;
    logic [7:0] ext_meta_reg, ext_sync_reg;
    logic [7:0] gate0_reg, gate1_reg;
    logic [6:0] dom_reg, dom_next;
    logic [8:0] periph_reg, gate_vec, base_vec;
    logic wake_go_reg, conv_on_reg, conv_prev_reg, conv_ext_reg;
    logic asy, sleep_go, ext_wake, usb_async, wake_hit;
    logic [8:0] wake_vec;
    logic dly_start, dly_done;
    logic [7:0] dly_load;

    // Domains kept per mode, bit order tosc, main, asy, adc, io, flash, cpu.
    function automatic logic [6:0] mode_domains(input logic [2:0] m, input logic a);
        case (m)
            MODE_IDLE: mode_domains = {a, 6'h3C};
            MODE_NRM: mode_domains = {a, 6'h38};
            MODE_PDOWN: mode_domains = 7'h00;
            MODE_PSAVE: mode_domains = {a, 6'h10};
            MODE_STBY: mode_domains = 7'h20;
            MODE_XSTBY: mode_domains = {a, 1'b1, a, 4'h0};
            default: mode_domains = {a, 6'h3F};
        endcase
    endfunction : mode_domains

    // Wake sources per mode, bit order usb async, usb sync, other io, watchdog,
    // converter, spm, timer2, address match, external and pin change.
    function automatic logic [8:0] mode_wake(input logic [2:0] m, input logic a);
        case (m)
            MODE_IDLE: mode_wake = 9'h1FF;
            MODE_NRM: mode_wake = 9'h1BB | {6'h00, a, 2'h0};
            MODE_PDOWN, MODE_STBY: mode_wake = 9'h123;
            MODE_PSAVE, MODE_XSTBY: mode_wake = 9'h127;
            default: mode_wake = 9'h000;
        endcase
    endfunction : mode_wake

    // Only documented encodings count; standby needs an external crystal.
    function automatic logic mode_valid(input logic [2:0] m, input logic xtal);
        case (m)
            MODE_IDLE, MODE_NRM, MODE_PDOWN, MODE_PSAVE: mode_valid = 1'b1;
            MODE_STBY, MODE_XSTBY: mode_valid = xtal;
            default: mode_valid = 1'b0;
        endcase
    endfunction : mode_valid

    // Wait until the clock is usable again after a wake event.
    function automatic logic [7:0] startup_cyc(input logic [2:0] m);
        case (m)
            MODE_STBY, MODE_XSTBY: startup_cyc = XSTBY_WAKE_CYC;
            MODE_PDOWN, MODE_PSAVE: startup_cyc = PDOWN_STARTUP_CYC;
            default: startup_cyc = RUNNING_WAKE_CYC;
        endcase
    endfunction : startup_cyc

    assign asy = LINK.timer2_async_select;

    // External interrupt pins come from outside the clock domain.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ext_meta_reg <= 8'h00;
            ext_sync_reg <= 8'h00;
        end else begin
            ext_meta_reg <= EXT_IRQ_REQ;
            ext_sync_reg <= ext_meta_reg;
        end
    end

    // Upper lines wake from every mode except Idle only when set up as level interrupts.
    assign ext_wake = PIN_CHANGE | (|ext_sync_reg[3:0]) |
        ((mode_reg == MODE_IDLE) ? (|ext_sync_reg[7:4]) :
        (|(ext_sync_reg[7:4] & EXT_HI_LEVEL))); // RULE_07
    assign usb_async = BUS_VOLTAGE_TRANSITION_IRQ | BUS_WAKE_IRQ |
        ID_PIN_TRANSITION_IRQ | HOST_WAKE_IRQ; // RULE_08
    assign wake_vec = {usb_async, USB_SYNC_IRQ, OTHER_IO_IRQ, WDT_IRQ, CONV_DONE,
        SPM_READY, TIMER2_EVENT, TWI_ADDR_MATCH, ext_wake};
    assign wake_hit = |(wake_vec & mode_wake(mode_reg, asy)); // RULE_05
    // A request without the enable bit or with a bad encoding leaves the core running.
    assign sleep_go = LINK.sleep_exec & LINK.sleep_enable_bit &
        mode_valid(LINK.sleep_mode_select, LINK.ext_crystal_sel); // RULE_24 RULE_01

    // Sleep state and the mode latched at the sleep command.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_reg <= ST_RUN;
            mode_reg <= MODE_IDLE;
        end else begin
            state_reg <= state_next;
            if (sleep_go && state_reg == ST_RUN) begin
                mode_reg <= LINK.sleep_mode_select;
            end
        end
    end

    // Sleep, clock start-up, then the extra core hold before the handler runs.
    always_comb begin
        state_next = state_reg;
        dly_start = 1'b0;
        dly_load = WAKE_HOLD_CYC;
        case (state_reg)
            ST_RUN: begin
                if (sleep_go) begin
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_hit) begin
                    state_next = ST_START;
                    dly_start = 1'b1;
                    dly_load = startup_cyc(mode_reg); // RULE_03
                end
            end
            ST_START: begin
                if (dly_done) begin
                    state_next = ST_HOLD;
                    dly_start = 1'b1;
                    dly_load = WAKE_HOLD_CYC; // RULE_23
                end
            end
            ST_HOLD: begin
                if (dly_done) begin
                    state_next = ST_RUN;
                end
            end
            default: state_next = ST_RUN;
        endcase
    end

    scg_delay u_delay (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .START(dly_start),
        .LOAD(dly_load),
        .DONE(dly_done)
    );

    // Domain enables; the timer oscillator follows the asynchronous select except in Power-down and Standby, where it is off.
    always_comb begin
        dom_next = {asy, 6'h3F}; // RULE_06
        case (state_reg)
            ST_RUN: dom_next = {asy, 6'h3F};
            ST_SLEEP: dom_next = mode_domains(mode_reg, asy); // RULE_04 RULE_02
            ST_START: dom_next = mode_domains(mode_reg, asy) | 7'h20;
            ST_HOLD: dom_next = {asy, 6'h3E};
            default: dom_next = {asy, 6'h3F};
        endcase
    end

    // Gate registers keep only writable bits, so reserved bits read zero.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            gate0_reg <= GATE_RST;
            gate1_reg <= GATE_RST;
        end else begin
            if (LINK.gate_wr[0]) begin
                gate0_reg <= LINK.gate_wdata & G0_MASK; // RULE_13
            end
            if (LINK.gate_wr[1]) begin
                gate1_reg <= LINK.gate_wdata & G1_MASK; // RULE_18
            end
        end
    end

    // Gate and source domain for each peripheral, in peripheral order.
    assign gate_vec = {gate1_reg[G1_USART1], gate1_reg[G1_TIM3], gate1_reg[G1_USB],
        gate0_reg[G0_ADC], gate0_reg[G0_SPI], gate0_reg[G0_TIM1], gate0_reg[G0_TIM0],
        gate0_reg[G0_TIM2] & ~asy, gate0_reg[G0_TWI]}; // RULE_14
    assign base_vec = {dom_next[D_IO], dom_next[D_IO], dom_next[D_IO], dom_next[D_ADC],
        dom_next[D_IO], dom_next[D_IO], dom_next[D_IO],
        asy ? dom_next[D_ASY] : dom_next[D_IO], dom_next[D_IO]};

    // The gate only removes the enable, so a peripheral freezes and later resumes
    // from where it stood; in deep modes the domain is off anyway.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            dom_reg <= 7'h3F;
            periph_reg <= 9'h1FF;
        end else begin
            dom_reg <= dom_next;
            periph_reg <= base_vec & ~gate_vec; // RULE_09 RULE_10 RULE_12 RULE_15
        end
    end

    // Converter enable is left alone by sleep; a fresh enable flags an
    // extended conversion, and a new enable beats a conversion start.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            conv_on_reg <= 1'b0;
            conv_prev_reg <= 1'b0;
            conv_ext_reg <= 1'b0;
        end else begin
            conv_on_reg <= LINK.converter_on; // RULE_19
            conv_prev_reg <= conv_on_reg;
            if (conv_on_reg && !conv_prev_reg) begin
                conv_ext_reg <= 1'b1; // RULE_20
            end else if (CONV_START) begin
                conv_ext_reg <= 1'b0;
            end
        end
    end

    // One-cycle wake notice on the first running cycle after the core hold.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            wake_go_reg <= 1'b0;
        end else begin
            wake_go_reg <= (state_reg == ST_HOLD) && dly_done; // RULE_23
        end
    end

    assign DOMAIN_EN = dom_reg;
    assign PERIPH_CLK_EN = periph_reg;
    assign CONV_ENABLED = conv_on_reg;
    assign CONV_EXTENDED = conv_ext_reg;
    assign CMP_MUX_ALLOW = ~gate0_reg[G0_ADC]; // RULE_17
    assign LINK.core_halted = (state_reg != ST_RUN);
    assign LINK.wake_go = wake_go_reg;
    assign LINK.gate0_q = gate0_reg;
    assign LINK.gate1_q = gate1_reg;
    assign LINK.conv_extended = conv_ext_reg;
endmodule : scg_dev
`default_nettype wire

// file: rtl/scg_cpu.sv
// Controller end: Avalon-MM register slave that drives the sleep link.
`default_nettype none
module scg_cpu
    import scg_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    scg_link_if.cpu LINK,
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST
);
    logic ack_reg, wr_go, rd_first;
    logic [6:0] ctrl_reg;
    logic [31:0] rdata_reg, rdata_next;
    logic exec_reg, woke_reg;
    logic [1:0] gate_wr_reg;
    logic [7:0] gate_wdata_reg, gate_wdata_next;

    // One wait state on every access gives time to register read data.
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_reg;
    assign wr_go = AVS_WRITE & ack_reg & AVS_BYTEENABLE[0];
    assign rd_first = AVS_READ & ~ack_reg;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (AVS_READ | AVS_WRITE) & ~ack_reg;
        end
    end

    // Read mux; unmapped addresses read zero.
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (AVS_ADDRESS)
            ADDR_CTRL: rdata_next = {25'h000_0000, ctrl_reg};
            ADDR_GATE0: rdata_next = {24'h00_0000, LINK.gate0_q};
            ADDR_GATE1: rdata_next = {24'h00_0000, LINK.gate1_q};
            ADDR_STATUS: rdata_next = {29'h0000_0000, woke_reg, LINK.conv_extended,
                LINK.core_halted};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd_first) begin
            rdata_reg <= rdata_next;
        end
    end

    // A converter gate request is dropped while the converter is still on.
    always_comb begin
        gate_wdata_next = AVS_WRITEDATA[7:0];
        if (AVS_ADDRESS == ADDR_GATE0 && ctrl_reg[CTRL_CONV]) begin
            gate_wdata_next[G0_ADC] = 1'b0; // RULE_17 RULE_11
        end
    end

    // Control register and one-cycle link strobes.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ctrl_reg <= CTRL_RST;
            exec_reg <= 1'b0;
            gate_wr_reg <= 2'b00;
            gate_wdata_reg <= GATE_RST;
        end else begin
            exec_reg <= wr_go && AVS_ADDRESS == ADDR_SLEEP && !LINK.core_halted;
            gate_wr_reg <= {wr_go && AVS_ADDRESS == ADDR_GATE1,
                wr_go && AVS_ADDRESS == ADDR_GATE0};
            if (wr_go) begin
                gate_wdata_reg <= gate_wdata_next;
            end
            if (wr_go && AVS_ADDRESS == ADDR_CTRL) begin
                ctrl_reg <= AVS_WRITEDATA[6:0];
            end
        end
    end

    // Wake flag is sticky; a wake in the clearing cycle is kept.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            woke_reg <= 1'b0;
        end else if (LINK.wake_go) begin
            woke_reg <= 1'b1;
        end else if (wr_go && AVS_ADDRESS == ADDR_STATUS && AVS_WRITEDATA[STAT_WOKE]) begin
            woke_reg <= 1'b0;
        end
    end

    assign AVS_READDATA = rdata_reg;
    assign LINK.sleep_mode_select = ctrl_reg[CTRL_MODE_LSB +: 3];
    assign LINK.sleep_enable_bit = ctrl_reg[CTRL_SE]; // RULE_22
    assign LINK.sleep_exec = exec_reg; // RULE_22
    assign LINK.gate_wr = gate_wr_reg;
    assign LINK.gate_wdata = gate_wdata_reg;
    assign LINK.timer2_async_select = ctrl_reg[CTRL_T2AS];
    assign LINK.ext_crystal_sel = ctrl_reg[CTRL_XTAL]; // RULE_21
    assign LINK.converter_on = ctrl_reg[CTRL_CONV];
endmodule : scg_cpu
`default_nettype wire

// file: tb/scg_properties.sv
// Concurrent checks on the link between the controller end and the device end.
`default_nettype none
module scg_properties
    import scg_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [2:0] sleep_mode_select,
    input wire logic sleep_enable_bit,
    input wire logic sleep_exec,
    input wire logic [1:0] gate_wr,
    input wire logic [7:0] gate_wdata,
    input wire logic ext_crystal_sel,
    input wire logic converter_on,
    input wire logic core_halted,
    input wire logic wake_go,
    input wire logic [7:0] gate0_q,
    input wire logic [7:0] gate1_q,
    input wire logic conv_extended
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // A sleep command seen while the core still runs.
    sequence s_req;
        sleep_exec && !core_halted;
    endsequence
    // A wake ends with one pulse on the first running cycle.
    sequence s_wake;
        $fell(core_halted) ##1 !wake_go;
    endsequence
    a_xstby_entry: assert property (s_req ##0 (sleep_enable_bit && ext_crystal_sel
        && sleep_mode_select == MODE_XSTBY) |=> core_halted) else $error("no sleep entry");
    a_bad_request: assert property (s_req ##0 (!sleep_enable_bit
        || sleep_mode_select[2:1] == 2'b10
        || (sleep_mode_select[2:1] == 2'b11 && !ext_crystal_sel)) |=> !core_halted)
        else $error("refused request slept");
    a_wake_pulse: assert property (wake_go |-> s_wake) else $error("bad wake pulse");
    // Four hold cycles plus at least one start-up cycle precede any wake.
    a_hold_min: assert property ($fell(core_halted) |-> $past(core_halted, 5))
        else $error("wake too early");
    a_xstby_wake: assert property ($fell(core_halted) && sleep_mode_select == MODE_XSTBY
        |-> $past(core_halted, 10)) else $error("standby wake too early");
    a_gate0_write: assert property (gate_wr[0] |=> gate0_q == ($past(gate_wdata) & G0_MASK))
        else $error("gate0 contents wrong");
    a_gate1_write: assert property (gate_wr[1] |=> gate1_q == ($past(gate_wdata) & G1_MASK))
        else $error("gate1 contents wrong");
    a_gate_hold: assert property (!gate_wr |=> $stable(gate0_q) && $stable(gate1_q))
        else $error("gate changed unasked");
    a_conv_ext: assert property ($rose(converter_on) |-> ##2 conv_extended)
        else $error("extended flag missing");
endmodule : scg_properties
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for both ends of the sleep clock gating link.
`default_nettype none
module tb_top
    import scg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] irq = 8'h00;
    logic [3:0] lvl = 4'h0;
    logic [12:0] src = 13'h0000;
    logic [4:0] adr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h00000000;
    logic [31:0] rdat;
    logic [31:0] q;
    logic wrq;
    logic [6:0] dom;
    logic [8:0] pen;
    logic cen;
    logic cext;
    logic cmux;
    int errors = 0;
    int checked = 0;
    int n;
    // Rows: control byte, wake source index, expected domains, cycles until the wake pulse.
    logic [31:0] rows [10] = '{32'h28063C07, 32'h29033807, 32'h2A080009, 32'h2A090009,
        32'h2A0A0009, 32'h2A0B0009, 32'h2B021009, 32'h2E00200C, 32'h2F01200C, 32'h3F05700C};
    logic [7:0] bad [4] = '{8'h0C, 8'h0D, 8'h0E, 8'h00};
    always #50 clk = ~clk;
    scg_link_if lnk ();
    wire halted = lnk.core_halted;
    wire wgo = lnk.wake_go;
    // Short start-up keeps the power-down wake count small.
    scg_dev #(.PDOWN_STARTUP_CYC(8'h03)) i_scg_dev (.CLK(clk), .SYS_RST(rst), .LINK(lnk.dev),
        .EXT_IRQ_REQ(irq), .EXT_HI_LEVEL(lvl), .PIN_CHANGE(src[0]), .TWI_ADDR_MATCH(src[1]),
        .TIMER2_EVENT(src[2]), .SPM_READY(src[3]), .CONV_DONE(src[4]), .WDT_IRQ(src[5]),
        .OTHER_IO_IRQ(src[6]), .USB_SYNC_IRQ(src[7]), .BUS_VOLTAGE_TRANSITION_IRQ(src[8]),
        .BUS_WAKE_IRQ(src[9]), .ID_PIN_TRANSITION_IRQ(src[10]), .HOST_WAKE_IRQ(src[11]),
        .CONV_START(src[12]), .DOMAIN_EN(dom), .PERIPH_CLK_EN(pen), .CONV_ENABLED(cen),
        .CONV_EXTENDED(cext), .CMP_MUX_ALLOW(cmux));
    scg_cpu i_scg_cpu (.CLK(clk), .SYS_RST(rst), .LINK(lnk.cpu), .AVS_ADDRESS(adr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF),
        .AVS_READDATA(rdat), .AVS_WAITREQUEST(wrq));
    scg_properties i_scg_properties (.CLK(clk), .SYS_RST(rst),
        .sleep_mode_select(lnk.sleep_mode_select), .sleep_enable_bit(lnk.sleep_enable_bit),
        .sleep_exec(lnk.sleep_exec), .gate_wr(lnk.gate_wr), .gate_wdata(lnk.gate_wdata),
        .ext_crystal_sel(lnk.ext_crystal_sel), .converter_on(lnk.converter_on),
        .core_halted(lnk.core_halted), .wake_go(lnk.wake_go), .gate0_q(lnk.gate0_q),
        .gate1_q(lnk.gate1_q), .conv_extended(lnk.conv_extended));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Waitrequest and read data are taken at the rising edge, before its own updates land.
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int k;
        logic ok;
        k = 0;
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        do begin
            @(posedge clk);
            ok = (wrq === 1'b0);
            k++;
        end while (!ok && k < 20);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(negedge clk);
        if (!ok) begin
            errors++;
            final_report();
        end
    endtask : bus

    task automatic wake();
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (wgo !== 1'b1 && n < 40);
        if (n >= 40) begin
            errors++;
            final_report();
        end
    endtask : wake

    task automatic nap(input logic [7:0] c);
        bus(1'b1, ADDR_CTRL, {24'h000000, c});
        bus(1'b1, ADDR_SLEEP, 32'h00000001);
        repeat (3) @(negedge clk);
    endtask : nap

    task automatic final_report();
        $display("Counts: %0d checks, %0d mismatches", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    // Main sequence; every wait inside the tasks is bounded.
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(negedge clk);
        foreach (rows[i]) begin
            nap(rows[i][31:24]);
            chk("domains", 32'(rows[i][14:8]), 32'(dom));
            @(posedge clk);
            src[rows[i][19:16]] <= 1'b1;
            wake();
            chk("wake cycles", 32'(rows[i][7:0]), n);
            @(posedge clk);
            src[rows[i][19:16]] <= 1'b0;
            bus(1'b0, ADDR_STATUS, 32'h0);
            chk("status", 32'h4, q);
            bus(1'b1, ADDR_STATUS, 32'h4);
        end
        $display("test rows done");
        // A second reset in mid-run must also clear the asynchronous select.
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(negedge clk);
        chk("domains", 32'h3F, 32'(dom));
        chk("clocks", 32'h1FF, 32'(pen));
        bus(1'b0, ADDR_GATE0, 32'h0);
        chk("gate0", 32'h0, q);
        $display("test reset done");
        bus(1'b1, ADDR_GATE0, 32'hFF);
        bus(1'b0, ADDR_GATE0, 32'h0);
        chk("gate0", 32'hED, q);
        bus(1'b1, ADDR_GATE1, 32'hFF);
        bus(1'b0, ADDR_GATE1, 32'h0);
        chk("gate1", 32'h89, q);
        chk("clocks", 32'h000, 32'(pen));
        bus(1'b1, ADDR_CTRL, 32'h10);
        repeat (3) @(negedge clk);
        chk("timer2 clock", 32'h002, 32'(pen));
        bus(1'b1, ADDR_GATE0, 32'h0);
        bus(1'b1, ADDR_GATE1, 32'h0);
        repeat (3) @(negedge clk);
        chk("clocks", 32'h1FF, 32'(pen));
        $display("test gates done");
        bus(1'b1, ADDR_CTRL, 32'h40);
        repeat (3) @(negedge clk);
        chk("conv extended", 32'h1, 32'(cext));
        bus(1'b1, ADDR_GATE0, 32'h01);
        bus(1'b0, ADDR_GATE0, 32'h0);
        chk("conv gate", 32'h0, q);
        chk("mux allow", 32'h1, 32'(cmux));
        @(posedge clk);
        src[12] <= 1'b1;
        @(posedge clk);
        src[12] <= 1'b0;
        @(negedge clk);
        chk("conv extended", 32'h0, 32'(cext));
        nap(8'h4A);
        @(posedge clk);
        src[2] <= 1'b1;
        irq[7] <= 1'b1;
        repeat (20) @(negedge clk);
        chk("masked wake", 32'h1, 32'(halted));
        chk("conv enabled", 32'h1, 32'(cen));
        @(posedge clk);
        lvl[3] <= 1'b1;
        wake();
        @(posedge clk);
        src[2] <= 1'b0;
        irq[7] <= 1'b0;
        lvl[3] <= 1'b0;
        @(negedge clk);
        chk("level wake", 32'h0, 32'(halted));
        $display("test converter done");
        foreach (bad[i]) begin
            nap(bad[i]);
            chk("refused sleep", 32'h0, 32'(halted));
        end
        bus(1'b0, 5'h14, 32'h0);
        chk("unmapped", 32'h0, q);
        $display("test refusals done");
        final_report();
    end
endmodule : tb_top
`default_nettype wire
